// File: cmsl_pkg.sv
// shared constants, types and helpers for the mode and stamp lock block
// assumes one 100 MHz clock shared by both ends of the link
package cmsl_pkg;

   localparam int ID_W   = 11;
   localparam int DATA_W = 8;
   localparam int NUM_MB = 4;

   // register byte offsets on the apb side
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_STAT   = 8'h04;
   localparam logic [7:0] OFS_MASK   = 8'h08;
   localparam logic [7:0] OFS_STATE  = 8'h0c;
   localparam logic [7:0] OFS_TXREQ  = 8'h10;
   localparam logic [7:0] OFS_MBCFG  = 8'h14;
   localparam logic [7:0] OFS_MBDATA = 8'h20;

   // module_control_reg fields
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_AL_BIT   = 3;
   localparam int CTRL_LOCK_BIT = 4;
   localparam logic [2:0] MODE_INIT   = 3'h0;
   localparam logic [2:0] MODE_NORMAL = 3'h1;
   localparam logic [2:0] MODE_ABT    = 3'h2;
   localparam logic [2:0] MODE_RXONLY = 3'h3;
   localparam logic [2:0] MODE_SSHOT  = 3'h4;
   localparam logic [2:0] RST_MODE    = MODE_INIT;

   // status / mask bits
   localparam int ST_VALID  = 0;
   localparam int ST_TXDONE = 1;
   localparam int ST_TXDROP = 2;
   localparam int ST_LOCKED = 3;
   localparam int ST_W      = 4;
   localparam logic [3:0] RST_STAT = 4'h0;
   localparam logic [3:0] RST_MASK = 4'h0;

   // transmit request, state and buffer fields
   localparam int TX_ID_LSB   = 0;
   localparam int TX_DATA_LSB = 11;
   localparam int TX_REM_BIT  = 19;
   localparam int TX_GO_BIT   = 31;
   localparam int STATE_STAMP = 0;
   localparam int STATE_LOCKD = 1;
   localparam int STATE_PEND  = 2;
   localparam int MB_RX_LSB   = 0;
   localparam int MB_RDY_LSB  = 4;
   localparam int MB_ID_LSB   = 8;
   localparam int MB_NEW_BIT  = 19;

   // timing
   localparam int CLK_PERIOD_NS   = 10;
   localparam int STAMP_PERIOD_NS = 160;
   localparam int STAMP_CYC       = STAMP_PERIOD_NS / CLK_PERIOD_NS;
   localparam int STAMP_W         = $clog2(STAMP_CYC);
   localparam logic [1:0] BUSY_CYC = 2'h3;

   // transmit error counter of the far node
   localparam logic [7:0] TEC_STEP    = 8'h08;
   localparam logic [7:0] TEC_PASSIVE = 8'h80;
   localparam logic [7:0] TEC_MAX     = 8'hff;

   typedef enum logic [2:0] {D_IDLE = 3'b001, D_SEND = 3'b010, D_WAIT = 3'b100} cmsl_dst_e;
   typedef enum logic [2:0] {N_IDLE = 3'b001, N_SEND = 3'b010, N_ACKW = 3'b100} cmsl_nst_e;

   // arbitration: lower id wins, a data frame beats a remote frame of equal id
   function automatic logic cmsl_wins(input logic [ID_W-1:0] a_id,
                                      input logic            a_rem,
                                      input logic [ID_W-1:0] b_id,
                                      input logic            b_rem);
      return (a_id < b_id) || ((a_id == b_id) && !(a_rem && !b_rem));
   endfunction

endpackage

// File: cmsl_link_if.sv
// frame level link between the controller and one far node
// assumes both ends run on the same clock; every signal is a flop output
`timescale 1ns/1ps
interface cmsl_link_if;
   import cmsl_pkg::*;
   logic              dev_tx_valid;
   logic [ID_W-1:0]   dev_tx_id;
   logic              dev_tx_remote;
   logic [DATA_W-1:0] dev_tx_data;
   logic              dev_ack;
   logic              node_tx_valid;
   logic [ID_W-1:0]   node_tx_id;
   logic              node_tx_remote;
   logic [DATA_W-1:0] node_tx_data;
   logic              node_ack;
   logic              node_err_active;
   logic              node_err_passive;

   modport dev (output dev_tx_valid, dev_tx_id, dev_tx_remote, dev_tx_data, dev_ack,
                input  node_tx_valid, node_tx_id, node_tx_remote, node_tx_data, node_ack,
                input  node_err_active, node_err_passive);
   modport node (input  dev_tx_valid, dev_tx_id, dev_tx_remote, dev_tx_data, dev_ack,
                 output node_tx_valid, node_tx_id, node_tx_remote, node_tx_data, node_ack,
                 output node_err_active, node_err_passive);
endinterface

// File: cmsl_node.sv
// far node: a plain bus participant that sends frames and acks ours
// assumes the controller end on the other side of cmsl_link_if
`timescale 1ns/1ps
module cmsl_node
   import cmsl_pkg::*;
(
   input  wire logic              sys_clk_i,
   input  wire logic              rst_i,
   cmsl_link_if.node              bus,
   input  wire logic              req_i,
   input  wire logic [ID_W-1:0]   req_id_i,
   input  wire logic [DATA_W-1:0] req_data_i,
   input  wire logic              req_remote_i,
   output logic                   busy_o,
   output logic                   done_o,
   output logic [7:0]             tec_o,
   output logic                   err_passive_o,
   output logic                   rx_valid_o,
   output logic [ID_W-1:0]        rx_id_o,
   output logic [DATA_W-1:0]      rx_data_o,
   output logic                   rx_remote_o
);

   typedef struct packed {
      cmsl_nst_e         st;
      logic              pend;
      logic [ID_W-1:0]   tx_id;
      logic [DATA_W-1:0] tx_data;
      logic              tx_rem;
      logic              tx_valid;
      logic              ack;
      logic              err_a;
      logic              err_p;
      logic [7:0]        tec;
      logic              passive;
      logic              done;
      logic [1:0]        busy;
      logic              rx_valid;
      logic [ID_W-1:0]   rx_id;
      logic [DATA_W-1:0] rx_data;
      logic              rx_rem;
   } cmsl_node_s;

   cmsl_node_s q;
   cmsl_node_s d;
   logic       dev_won;

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      d = q;
      d.tx_valid = 1'b0;
      d.ack = 1'b0;
      d.err_a = 1'b0;
      d.err_p = 1'b0;
      d.done = 1'b0;
      d.rx_valid = 1'b0;
      dev_won = bus.dev_tx_valid &&
                !(q.st == N_SEND && cmsl_wins(q.tx_id, q.tx_rem, bus.dev_tx_id,
                                              bus.dev_tx_remote));
      // both ends track the same busy window, so starts only clash in one cycle
      if (bus.dev_tx_valid || bus.node_tx_valid) begin
         d.busy = BUSY_CYC;
      end else if (q.busy != 2'h0) begin
         d.busy = q.busy - 2'h1;
      end
      if (req_i && !q.pend) begin
         d.pend = 1'b1;
         d.tx_id = req_id_i;
         d.tx_data = req_data_i;
         d.tx_rem = req_remote_i;
      end
      unique case (q.st)
         N_IDLE: begin
            if (q.pend && q.busy == 2'h0 && !bus.dev_tx_valid) begin
               d.tx_valid = 1'b1;
               d.st = N_SEND;
            end
         end
         N_SEND: begin
            d.st = dev_won ? N_IDLE : N_ACKW; // lost arbitration retries later
         end
         N_ACKW: begin
            d.st = N_IDLE;
            if (bus.dev_ack) begin
               d.pend = 1'b0;
               d.done = 1'b1;
               if (q.tec != 8'h00) d.tec = q.tec - 8'h01;
            end else begin
               // flag kind follows the count before this miss is added
               d.err_a = q.tec < TEC_PASSIVE;
               d.err_p = q.tec >= TEC_PASSIVE;
               d.tec = (q.tec > TEC_MAX - TEC_STEP) ? TEC_MAX : q.tec + TEC_STEP;
            end
         end
      endcase
      // a normal node acks every frame it sees
      if (dev_won) begin
         d.ack = 1'b1;
         d.rx_valid = 1'b1;
         d.rx_id = bus.dev_tx_id;
         d.rx_data = bus.dev_tx_data;
         d.rx_rem = bus.dev_tx_remote;
      end
      d.passive = d.tec >= TEC_PASSIVE;
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         q <= '0;
         q.st <= N_IDLE;
      end else begin
         q <= d;
      end
   end

   assign bus.node_tx_valid    = q.tx_valid;
   assign bus.node_tx_id       = q.tx_id;
   assign bus.node_tx_remote   = q.tx_rem;
   assign bus.node_tx_data     = q.tx_data;
   assign bus.node_ack         = q.ack;
   assign bus.node_err_active  = q.err_a;
   assign bus.node_err_passive = q.err_p;
   assign busy_o        = q.pend;
   assign done_o        = q.done;
   assign tec_o         = q.tec;
   assign err_passive_o = q.passive;
   assign rx_valid_o    = q.rx_valid;
   assign rx_id_o       = q.rx_id;
   assign rx_data_o     = q.rx_data;
   assign rx_remote_o   = q.rx_rem;

endmodule

// File: cmsl_dev.sv
// controller end: operating modes, receive buffers and stamp toggle lock
// assumes an apb master for software and the far node on cmsl_link_if
`timescale 1ns/1ps
module cmsl_dev
   import cmsl_pkg::*;
(
   input  wire logic        sys_clk_i,
   input  wire logic        rst_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic [31:0]      prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   output logic             irq_o,
   output logic             stamp_toggle_output_o,
   cmsl_link_if.dev         bus
);

   typedef struct packed {
      cmsl_dst_e                      st;
      logic [2:0]                     mode;
      logic                           al;
      logic                           lock;
      logic [ST_W-1:0]                stat;
      logic [ST_W-1:0]                mask;
      logic                           tx_pend;
      logic [ID_W-1:0]                tx_id;
      logic [DATA_W-1:0]              tx_data;
      logic                           tx_rem;
      logic [NUM_MB-1:0]              mb_rx;
      logic [NUM_MB-1:0]              mb_rdy;
      logic [NUM_MB-1:0]              mb_new;
      logic [NUM_MB-1:0][DATA_W-1:0]  mb_data;
      logic [NUM_MB-1:0][ID_W-1:0]    mb_id;
      logic                           locked;
      logic                           stamp;
      logic [STAMP_W-1:0]             tick;
      logic [1:0]                     busy;
      logic                           tx_valid;
      logic                           ack;
      logic [ID_W-1:0]                rx_id;
      logic [DATA_W-1:0]              rx_data;
      logic                           rx_rem;
      logic [1:0]                     rx_stg;
      logic [31:0]                    prdata;
      logic                           pready;
      logic                           pslverr;
      logic                           irq;
   } cmsl_dev_s;

   cmsl_dev_s       q;
   cmsl_dev_s       d;
   logic [ST_W-1:0] ev;
   logic            node_won;
   logic            can_tx;
   logic            wr_acc;
   logic            rd_acc;
   logic [1:0]      mb;
   logic [1:0]      ra;

   // buffer data words sit in one aligned block of four
   function automatic logic is_mbdata(input logic [7:0] a);
      return a[7:4] == OFS_MBDATA[7:4] && a[1:0] == 2'h0;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      d = q;
      ev = '0;
      d.tx_valid = 1'b0;
      d.ack = 1'b0;
      d.pready = 1'b0;
      d.pslverr = 1'b0;
      can_tx = q.mode != MODE_INIT && q.mode != MODE_RXONLY;
      node_won = bus.node_tx_valid &&
                 !(q.st == D_SEND && cmsl_wins(q.tx_id, q.tx_rem, bus.node_tx_id,
                                               bus.node_tx_remote));
      wr_acc = psel_i && penable_i && q.pready && pwrite_i;
      rd_acc = psel_i && penable_i && q.pready && !pwrite_i;
      mb = q.rx_id[1:0];
      ra = paddr_i[3:2];

      // same busy window as the far node keeps both starts aligned
      if (bus.dev_tx_valid || bus.node_tx_valid) begin
         d.busy = BUSY_CYC;
      end else if (q.busy != 2'h0) begin
         d.busy = q.busy - 2'h1;
      end

      // apb setup cycle: answer is ready for the access cycle
      if (psel_i && !penable_i) begin
         d.pready = 1'b1;
         d.prdata = 32'h0;
         unique case (paddr_i)
            OFS_CTRL:  d.prdata = {27'h0, q.lock, q.al, q.mode};
            OFS_STAT:  d.prdata = {28'h0, q.stat};
            OFS_MASK:  d.prdata = {28'h0, q.mask};
            OFS_STATE: d.prdata = {29'h0, q.tx_pend, q.locked, q.stamp};
            OFS_TXREQ: d.prdata = {q.tx_pend, 11'h0, q.tx_rem, q.tx_data, q.tx_id};
            OFS_MBCFG: d.prdata = {24'h0, q.mb_rdy, q.mb_rx};
            default: begin
               if (is_mbdata(paddr_i)) begin
                  d.prdata = {12'h0, q.mb_new[ra], q.mb_id[ra], q.mb_data[ra]};
               end else begin
                  d.pslverr = 1'b1; // unmapped reads zero with an error
               end
            end
         endcase
      end

      // apb access effects; hardware sets below win over these clears
      if (wr_acc) begin
         unique case (paddr_i)
            OFS_CTRL: begin
               d.mode = pwdata_i[CTRL_MODE_LSB +: 3];
               d.al = pwdata_i[CTRL_AL_BIT];
               d.lock = pwdata_i[CTRL_LOCK_BIT];
            end
            OFS_STAT: d.stat = q.stat & ~pwdata_i[ST_W-1:0];
            OFS_MASK: d.mask = pwdata_i[ST_W-1:0];
            OFS_TXREQ: begin
               if (pwdata_i[TX_GO_BIT] && !q.tx_pend) begin
                  d.tx_pend = 1'b1;
                  d.tx_id = pwdata_i[TX_ID_LSB +: ID_W];
                  d.tx_data = pwdata_i[TX_DATA_LSB +: DATA_W];
                  d.tx_rem = pwdata_i[TX_REM_BIT];
               end
            end
            OFS_MBCFG: begin
               // direction only changes on a buffer that is not ready
               for (int m = 0; m < NUM_MB; m++) begin
                  if (!q.mb_rdy[m]) d.mb_rx[m] = pwdata_i[MB_RX_LSB + m];
               end
               d.mb_rdy = pwdata_i[MB_RDY_LSB +: NUM_MB];
            end
            default: d.mask = q.mask;
         endcase
      end
      if (rd_acc && is_mbdata(paddr_i)) begin
         d.mb_new[ra] = 1'b0; // reading a buffer consumes its new flag
      end

      // own transmission
      unique case (q.st)
         D_IDLE: begin
            if (q.tx_pend && can_tx && q.busy == 2'h0 && !bus.node_tx_valid) begin
               d.tx_valid = 1'b1;
               d.st = D_SEND;
            end
         end
         D_SEND: begin
            if (node_won) begin
               d.st = D_IDLE;
               // other modes, and single-shot with al clear, keep the request and retry
               if (q.mode == MODE_SSHOT && q.al) begin
                  d.tx_pend = 1'b0;
                  ev[ST_TXDROP] = 1'b1;
               end
            end else begin
               d.st = D_WAIT;
            end
         end
         D_WAIT: begin
            d.st = D_IDLE;
            if (bus.node_ack) begin
               d.tx_pend = 1'b0;
               ev[ST_TXDONE] = 1'b1;
            end else if (q.mode == MODE_SSHOT) begin
               d.tx_pend = 1'b0;
               ev[ST_TXDROP] = 1'b1;
            end
         end
      endcase

      // reception: capture, ack a cycle later, commit unless an active error is flagged
      d.rx_stg = {q.rx_stg[0], 1'b0};
      if (q.mode != MODE_INIT && node_won) begin
         d.rx_stg[0] = 1'b1;
         d.rx_id = bus.node_tx_id;
         d.rx_data = bus.node_tx_data;
         d.rx_rem = bus.node_tx_remote;
         d.ack = q.mode != MODE_RXONLY;
      end
      // an active flag destroys the frame; a passive one leaves it valid
      if (q.rx_stg[1] && !bus.node_err_active) begin
         ev[ST_VALID] = 1'b1;
         if (!q.rx_rem && q.mb_rx[mb] && q.mb_rdy[mb] &&
             !(q.mode == MODE_ABT && mb == 2'h0)) begin
            d.mb_data[mb] = q.rx_data;
            d.mb_id[mb] = q.rx_id;
            d.mb_new[mb] = 1'b1;
            if (mb == 2'h0 && q.lock) begin
               d.locked = 1'b1;
               ev[ST_LOCKED] = 1'b1;
            end
         end
      end

      // stamp toggle; dropping the lock bit rearms it
      if (!q.lock) d.locked = 1'b0;
      if (q.tick == STAMP_W'(STAMP_CYC - 1)) begin
         d.tick = '0;
         if (!(q.lock && q.locked)) d.stamp = ~q.stamp;
      end else begin
         d.tick = q.tick + 1'b1;
      end

      d.stat = d.stat | ev;
      d.irq = |(d.stat & d.mask);
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         q <= '0;
         q.st <= D_IDLE;
         q.mode <= RST_MODE;
         q.stat <= RST_STAT;
         q.mask <= RST_MASK;
      end else begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs, all from the state register
   assign prdata_o              = q.prdata;
   assign pready_o              = q.pready;
   assign pslverr_o             = q.pslverr;
   assign irq_o                 = q.irq;
   assign stamp_toggle_output_o = q.stamp;
   assign bus.dev_tx_valid      = q.tx_valid;
   assign bus.dev_tx_id         = q.tx_id;
   assign bus.dev_tx_remote     = q.tx_rem;
   assign bus.dev_tx_data       = q.tx_data;
   assign bus.dev_ack           = q.ack;

endmodule

// File: cmsl_chk.sv
// assertions on the frame link between the controller end and the far node
// assumes one clock and a synchronous active high reset shared by both ends
`timescale 1ns/1ps
module cmsl_chk (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic dev_tx_valid_i,
   input wire logic dev_ack_i,
   input wire logic node_tx_valid_i,
   input wire logic node_ack_i,
   input wire logic node_err_active_i,
   input wire logic node_err_passive_i
);
   // one domain, so clock and reset are given once for all properties
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (rst_i);

   ////////////////////////////////////////////////////////////////////////
   // acknowledge only answers a frame of the other party, one cycle late
   a_ack_cause: assert property (dev_ack_i |-> $past(node_tx_valid_i))
      else $error("device ack without a node frame");
   a_ack_pulse: assert property (dev_ack_i |=> !dev_ack_i)
      else $error("device ack longer than one cycle");
   a_nack_cause: assert property (node_ack_i |-> $past(dev_tx_valid_i))
      else $error("node ack without a device frame");

   ////////////////////////////////////////////////////////////////////////
   // a lone unacked node frame must end in an error flag two cycles later;
   // a start shared with the device is left out since arbitration decides it
   a_noack_err: assert property ((node_tx_valid_i && !dev_tx_valid_i) ##1 !dev_ack_i
      |=> (node_err_active_i || node_err_passive_i))
      else $error("unacked node frame without error flag");
   a_err_cause: assert property ((node_err_active_i || node_err_passive_i)
      |-> $past(node_tx_valid_i, 2) && !$past(dev_ack_i))
      else $error("error flag without an unacked frame");
   a_err_excl: assert property (!(node_err_active_i && node_err_passive_i))
      else $error("active and passive flag together");
   a_err_pulse: assert property ((node_err_active_i || node_err_passive_i)
      |=> !(node_err_active_i || node_err_passive_i))
      else $error("error flag longer than one cycle");
   a_start_gap: assert property ((dev_tx_valid_i || node_tx_valid_i)
      |=> !(dev_tx_valid_i || node_tx_valid_i) [*3])
      else $error("frames closer than four cycles");
endmodule

// File: cmsl_tb_top.sv
// self-checking bench: controller end and far node joined by the link
// assumes apb access with zero wait states and one 100 MHz clock
`timescale 1ns/1ps
module cmsl_tb_top;
   import cmsl_pkg::*;
   logic              sys_clk_i = 1'b0;
   logic              rst_i = 1'b1;
   logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]        paddr = 8'h00;
   logic [31:0]       pwdata = 32'h0, prdata, rd;
   logic              pready, pslverr, irq, stamp, err, busy, done, errp, rx_v, rx_rem;
   logic              req = 1'b0, req_rem = 1'b0;
   logic [ID_W-1:0]   req_id = 11'h000, id, rx_id;
   logic [DATA_W-1:0] req_data = 8'h00, rx_dat;
   logic [7:0]        tec;
   int                num_errors = 0, checked = 0, seed = 37347, cyc = 0, n, k;
   int                n_act = 0, n_pas = 0, n_ack = 0, n_col = 0, col_s = 0;
   int                n_rx = 0, n_dn = 0;

   cmsl_link_if link ();
   cmsl_dev cmsl_dev_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .irq_o(irq),
      .stamp_toggle_output_o(stamp), .bus(link.dev));
   cmsl_node cmsl_node_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .bus(link.node),
      .req_i(req), .req_id_i(req_id), .req_data_i(req_data), .req_remote_i(req_rem),
      .busy_o(busy), .done_o(done), .tec_o(tec), .err_passive_o(errp),
      .rx_valid_o(rx_v), .rx_id_o(rx_id), .rx_data_o(rx_dat), .rx_remote_o(rx_rem));
   cmsl_chk cmsl_chk_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
      .dev_tx_valid_i(link.dev_tx_valid), .dev_ack_i(link.dev_ack),
      .node_tx_valid_i(link.node_tx_valid), .node_ack_i(link.node_ack),
      .node_err_active_i(link.node_err_active), .node_err_passive_i(link.node_err_passive));

   always #5 sys_clk_i = ~sys_clk_i;

   ////////////////////////////////////////////////////////////////////////
   // link event counters and the hang limit
   always @(posedge sys_clk_i) begin
      cyc++;
      n_act = n_act + int'(link.node_err_active);
      n_pas = n_pas + int'(link.node_err_passive);
      n_ack = n_ack + int'(link.dev_ack);
      n_col = n_col + int'(link.dev_tx_valid && link.node_tx_valid);
      n_rx = n_rx + int'(rx_v);
      n_dn = n_dn + int'(done);
      if (cyc == 20000) begin
         num_errors++;
         stop_test();
      end
   end

   task stop_test();
      $display("checks %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   // one apb transfer; the idle edge first keeps two transfers from colliding
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk_i);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk_i);
      penable <= 1'b1;
      do @(posedge sys_clk_i); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // node request held until taken; optionally wait for its ack
   task node_tx(input logic [ID_W-1:0] i, input logic rem, input logic w);
      @(posedge sys_clk_i);
      req <= 1'b1;
      req_id <= i;
      req_rem <= rem;
      req_data <= 8'($random(seed));
      do @(posedge sys_clk_i); while (busy !== 1'b0);
      req <= 1'b0;
      if (w) begin
         do @(posedge sys_clk_i); while (busy !== 1'b0);
      end
   endtask

   // cycles between two stamp changes, 40 when it stands still
   task stamp_gap(output int g);
      logic s;
      g = 0;
      s = stamp;
      while (stamp === s && g < 40) begin
         @(posedge sys_clk_i);
         #1;
         g++;
      end
      g = 0;
      s = stamp;
      while (stamp === s && g < 40) begin
         @(posedge sys_clk_i);
         #1;
         g++;
      end
   endtask

   // lost arbitration drops the frame only in single-shot with the policy set
   function automatic logic [31:0] exp_tx(logic [2:0] m, logic al, logic col);
      return (m == MODE_SSHOT && al && col) ? 32'h4 : 32'h2;
   endfunction

   // node (lower id) and device started at offset o from each other
   task trial(input logic [2:0] m, input logic al, input int o);
      apb(1'b1, OFS_STAT, 32'hf);
      apb(1'b1, OFS_CTRL, {27'h0, 1'b0, al, m});
      n_col = 0;
      n_rx = 0;
      n_dn = 0;
      fork
         begin
            repeat (o < 0 ? 0 : o) @(posedge sys_clk_i);
            apb(1'b1, OFS_TXREQ, 32'h8000_0100);
         end
         begin
            repeat (o < 0 ? -o : 0) @(posedge sys_clk_i);
            node_tx(11'h010, 1'b0, 1'b1);
         end
      join
      repeat (40) @(posedge sys_clk_i);
      apb(1'b0, OFS_STAT, 32'h0);
      chk("tx outcome", exp_tx(m, al, n_col > 0), rd & 32'h6);
      chk("node rx", {31'h0, exp_tx(m, al, n_col > 0) == 32'h2}, n_rx);
      chk("node rx frame", 32'h100, {12'h0, rx_rem, rx_dat, rx_id});
      chk("node done", 32'h1, n_dn);
      if (m == MODE_SSHOT && al) col_s = col_s + n_col;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      repeat (8) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      apb(1'b0, OFS_CTRL, 32'h0);
      chk("ctrl reset", {29'h0, RST_MODE}, rd);
      apb(1'b0, OFS_STAT, 32'h0);
      chk("status reset", {28'h0, RST_STAT}, rd);
      apb(1'b0, OFS_MASK, 32'h0);
      chk("mask reset", {28'h0, RST_MASK}, rd);
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, err});
      chk("unmapped data", 32'h0, rd);
      stamp_gap(n);
      chk("stamp gap", STAMP_CYC, n);
      // buffers: receive type may change only while not ready
      apb(1'b1, OFS_MBCFG, 32'hff);
      apb(1'b1, OFS_MBCFG, 32'hf0);
      apb(1'b0, OFS_MBCFG, 32'h0);
      chk("cfg while ready", 32'hff, rd);
      apb(1'b1, OFS_MBCFG, 32'h0f);
      apb(1'b1, OFS_MBCFG, 32'hff);
      // receive-only: another register is touched before leaving init
      apb(1'b1, OFS_MASK, 32'h1);
      apb(1'b1, OFS_CTRL, {29'h0, MODE_RXONLY});
      id = {9'($random(seed)), 2'b01};
      n_act = 0;
      n_pas = 0;
      n_ack = 0;
      node_tx(id, 1'b0, 1'b0);
      while (irq !== 1'b1) @(posedge sys_clk_i);
      chk("acks", 32'h0, n_ack);
      chk("active flags", 32'd16, n_act);
      chk("passive flags", 32'd1, n_pas);
      chk("tec", 32'h88, {24'h0, tec});
      chk("passive state", 32'h1, {31'h0, errp});
      apb(1'b0, OFS_MBDATA + 8'h04, 32'h0);
      chk("buffer 1", {12'h0, 1'b1, id, req_data}, rd);
      apb(1'b1, OFS_CTRL, {29'h0, MODE_NORMAL});
      while (busy !== 1'b0) @(posedge sys_clk_i);
      // the node keeps retrying until the mode change, so every counted miss adds 8
      chk("tec after ack", 8 * (n_act + n_pas) - 1, {24'h0, tec});
      // interrupt: mask, unmask, clear
      apb(1'b1, OFS_MASK, 32'h0);
      @(posedge sys_clk_i);
      #1;
      chk("irq masked", 32'h0, {31'h0, irq});
      apb(1'b1, OFS_MASK, 32'h1);
      @(posedge sys_clk_i);
      #1;
      chk("irq unmasked", 32'h1, {31'h0, irq});
      apb(1'b1, OFS_STAT, 32'h1);
      @(posedge sys_clk_i);
      #1;
      chk("irq cleared", 32'h0, {31'h0, irq});
      // stamp lock in normal mode
      apb(1'b1, OFS_CTRL, 32'h11);
      node_tx({9'($random(seed)), 2'b00}, 1'b1, 1'b1);
      apb(1'b0, OFS_STATE, 32'h0);
      chk("lock by remote", 32'h0, rd & 32'h2);
      node_tx({9'($random(seed)), 2'b10}, 1'b0, 1'b1);
      apb(1'b0, OFS_STATE, 32'h0);
      chk("lock by buffer 2", 32'h0, rd & 32'h2);
      stamp_gap(n);
      chk("stamp gap armed", STAMP_CYC, n);
      node_tx({9'($random(seed)), 2'b00}, 1'b0, 1'b1);
      apb(1'b0, OFS_STATE, 32'h0);
      chk("lock by buffer 0", 32'h2, rd & 32'h2);
      stamp_gap(n);
      chk("stamp held", 32'd40, n);
      apb(1'b0, OFS_STAT, 32'h0);
      chk("locked flag", 32'h8, rd & 32'h8);
      // auto block send mode: buffer 0 takes no frames, lock cannot trigger
      apb(1'b1, OFS_CTRL, 32'h01);
      apb(1'b1, OFS_CTRL, 32'h12);
      node_tx({9'($random(seed)), 2'b00}, 1'b0, 1'b1);
      apb(1'b0, OFS_STATE, 32'h0);
      chk("lock in block mode", 32'h0, rd & 32'h2);
      stamp_gap(n);
      chk("stamp gap block", STAMP_CYC, n);
      // arbitration loss swept over start offsets
      for (k = -4; k <= 4; k++) begin
         trial(MODE_SSHOT, 1'b1, k);
         trial(MODE_SSHOT, 1'b0, k);
         trial(MODE_NORMAL, 1'b1, k);
      end
      chk("collisions seen", 32'h1, {31'h0, col_s > 0});
      apb(1'b1, OFS_CTRL, {29'h0, MODE_INIT});
      stop_test();
   end
endmodule
